// file: src/otpw_map.svh
// Offsets, field positions, reset values and timing counts of the wiper link
`ifndef OTPW_MAP_SVH
`define OTPW_MAP_SVH

// Clock of both ends
`define OTPW_CLK_PERIOD_NS          5

// Target address: fixed upper pattern, low pair from constants or pins
`define OTPW_ADDR_UPPER             5'h0b
`define OTPW_ADDR_FIXED_LOW         2'h3

// Instruction byte fields
`define OTPW_CHANNEL_SELECT_BIT     7
`define OTPW_WIPER_TO_B_SHUTDOWN_BIT 6
`define OTPW_FUSE_PROGRAM_BIT       5
`define OTPW_FUSE_OVERRIDE_BIT      3

// Wiper preset and one-time-programming status codes
`define OTPW_MIDSCALE               8'h80
`define OTPW_OTP_READY              2'h0
`define OTPW_OTP_FAILED             2'h2
`define OTPW_OTP_DONE               2'h3

// Fuse programming time, and its cycle count
`define OTPW_PROG_TIME_MS           400
`define OTPW_PROG_CYCLES            ((`OTPW_PROG_TIME_MS * 1000000) / `OTPW_CLK_PERIOD_NS)

// Quarter of one SCL period made by the controller
`define OTPW_SCL_QUARTER_NS         250
`define OTPW_SCL_QUARTER_CYC        (`OTPW_SCL_QUARTER_NS / `OTPW_CLK_PERIOD_NS)

// Controller register offsets
`define OTPW_REG_CMD                8'h00
`define OTPW_REG_INSTR              8'h04
`define OTPW_REG_WDATA              8'h08
`define OTPW_REG_STATUS             8'h0c
`define OTPW_REG_RDATA              8'h10

// Command register fields
`define OTPW_CMD_READ_BIT           7
`define OTPW_CMD_WITH_DATA_BIT      8

// Status register fields
`define OTPW_STAT_BUSY_BIT          0
`define OTPW_STAT_NACK_BIT          1

`endif

// file: src/otpw_pkg.sv
// Types shared by both ends of the wiper link
package otpw_pkg;

	// Target byte phase
	typedef enum logic [2:0] {
		D_IDLE,
		D_ADDR,
		D_INSTR,
		D_WDATA,
		D_RDATA,
		D_IGNORE
	} otpw_dphase_type;

	// Controller sequencer
	typedef enum logic [1:0] {
		H_IDLE,
		H_START,
		H_BIT,
		H_STOP
	} otpw_hphase_type;

	// Whole state of the target
	typedef struct packed {
		otpw_dphase_type   st;
		logic [3:0]        cnt;
		logic [7:0]        sh;
		logic [7:0]        tx;
		logic              rd_idx;
		logic              drv;
		logic              ch;
		logic              shut;
		logic              ovr;
		logic [1:0][7:0]   wip;
		logic [1:0][7:0]   ovw;
		logic [1:0][7:0]   fcode;
		logic [1:0]        stat;
		logic              prog;
		logic [26:0]       pcnt;
		logic              init;
		logic              scl_d;
		logic              sda_d;
	} otpw_dev_state_type;

	// Whole state of the controller
	typedef struct packed {
		otpw_hphase_type   st;
		logic [1:0]        q;
		logic [7:0]        qcnt;
		logic [1:0]        bidx;
		logic [3:0]        bitn;
		logic [7:0]        sh;
		logic              scl_lo;
		logic              sda_lo;
		logic              nack;
		logic [6:0]        addr;
		logic              rd;
		logic              with_data;
		logic [7:0]        instr;
		logic [7:0]        wdata;
		logic [15:0]       rdata;
		logic [15:0]       rdout;
	} otpw_host_state_type;

endpackage

// file: src/otpw_link_if.sv
// Two-wire link between controller and wiper target
interface otpw_link_if;
	logic host_scl_out;
	logic host_scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Open-drain wires with pull-up: low when any driver pulls low
	assign scl = ~(host_scl_oe & ~host_scl_out);
	assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

	modport device (
		input  scl,
		input  sda,
		output dev_sda_out,
		output dev_sda_oe
	);

	modport host (
		input  scl,
		input  sda,
		output host_scl_out,
		output host_scl_oe,
		output host_sda_out,
		output host_sda_oe
	);
endinterface

// file: src/otpw_sync.sv
// Three-stage pin synchroniser with agreement filter
module otpw_sync
#(
	parameter int W = 1
)
(
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         reset_n_in,
	// Pins and filtered levels
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// Idle bus lines are high, so reset to high
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk_in or negedge reset_n_in)
			begin
				if (!reset_n_in)
				begin
					s1_r[i]      <= 1'b1;
					s2_r[i]      <= 1'b1;
					s3_r[i]      <= 1'b1;
					level_out[i] <= 1'b1;
				end
				else
				begin
					s1_r[i] <= pin_in[i];
					s2_r[i] <= s1_r[i];
					s3_r[i] <= s2_r[i];
					// Only an agreed value passes, hiding a metastable stage
					if (s2_r[i] == s3_r[i])
						level_out[i] <= s3_r[i];
				end
			end
		end
	endgenerate
endmodule

// file: src/otpw_target.sv
// Wiper target end: two-wire slave, two wiper registers and fuse control
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`include "otpw_map.svh"

module otpw_target
	import otpw_pkg::*;
#(
	parameter int PROG_CYCLES = `OTPW_PROG_CYCLES,
	parameter bit USE_ADDR_PINS = 1'b1
)
(
	// Clock and reset
	input  wire logic         CLK_IN,
	input  wire logic         RESET_N_IN,
	// Two-wire link
	otpw_link_if.device       LINK,
	// Address select pins
	input  wire logic         ADDR_SELECT_PIN_LOW_IN,
	input  wire logic         ADDR_SELECT_PIN_HIGH_IN,
	// Fuse array state read at power-up, burn result read at the end of a burn
	input  wire logic [1:0]   FUSE_STATUS_IN,
	input  wire logic [7:0]   FUSED_CODE0_IN,
	input  wire logic [7:0]   FUSED_CODE1_IN,
	input  wire logic         FUSE_FAIL_IN,
	// Resistor array control
	output logic              SHUTDOWN_OUT,
	output logic      [7:0]   WIPER0_CODE_OUT,
	output logic      [7:0]   WIPER1_CODE_OUT,
	// Fuse programming control
	output logic              FUSE_PROG_OUT,
	output logic      [7:0]   FUSE_BURN_CODE0_OUT,
	output logic      [7:0]   FUSE_BURN_CODE1_OUT,
	output logic      [1:0]   OTP_STATUS_OUT
);
	otpw_dev_state_type r;
	otpw_dev_state_type n;
	logic [3:0]         pins;
	logic               f_scl;
	logic               f_sda;
	logic               pin_lo;
	logic               pin_hi;
	logic               scl_rise;
	logic               scl_fall;
	logic               start_ev;
	logic               stop_ev;
	logic [6:0]         own_addr;

	// Value the resistor array sees for one channel
	function automatic logic [7:0] applied(input otpw_dev_state_type s, input logic c);
		applied = s.ovr ? s.ovw[c] : s.wip[c];
	endfunction

	// All link and strap inputs come from outside this clock
	otpw_sync #(.W(4)) u_sync
	(
		.clk_in     (CLK_IN),
		.reset_n_in (RESET_N_IN),
		.pin_in     ({ADDR_SELECT_PIN_HIGH_IN, ADDR_SELECT_PIN_LOW_IN, LINK.sda, LINK.scl}),
		.level_out  (pins)
	);

	// Filtered pins and bus events
	assign f_scl    = pins[0];
	assign f_sda    = pins[1];
	assign pin_lo   = pins[2];
	assign pin_hi   = pins[3];
	assign scl_rise = f_scl & ~r.scl_d;
	assign scl_fall = ~f_scl & r.scl_d;
	assign start_ev = f_scl & r.scl_d & ~f_sda & r.sda_d;
	assign stop_ev  = f_scl & r.scl_d & f_sda & ~r.sda_d;

	// Own address, low pair from pins or constant ones
	assign own_addr = {`OTPW_ADDR_UPPER, USE_ADDR_PINS ? {pin_hi, pin_lo} : `OTPW_ADDR_FIXED_LOW};

	// Next state of the whole target
	always_comb
	begin
		n       = r;
		n.scl_d = f_scl;
		n.sda_d = f_sda;

		// Preset once after reset from the fuse array
		if (!r.init)
		begin
			n.init     = 1'b1;
			n.stat     = FUSE_STATUS_IN;
			n.fcode[0] = FUSED_CODE0_IN;
			n.fcode[1] = FUSED_CODE1_IN;
			if (FUSE_STATUS_IN == `OTPW_OTP_DONE)
			begin
				n.wip[0] = FUSED_CODE0_IN;
				n.wip[1] = FUSED_CODE1_IN;
			end
			else
			begin
				n.wip[0] = `OTPW_MIDSCALE;
				n.wip[1] = `OTPW_MIDSCALE;
			end
		end

		// Fuse burn timer, result taken from the array at the end
		if (r.prog)
		begin
			if (r.pcnt == 27'(PROG_CYCLES - 1))
			begin
				n.prog = 1'b0;
				n.stat = FUSE_FAIL_IN ? `OTPW_OTP_FAILED : `OTPW_OTP_DONE;
			end
			else
				n.pcnt = r.pcnt + 27'h1;
		end

		// Bus byte engine
		if (start_ev)
		begin
			n.st  = D_ADDR;
			n.cnt = 4'h0;
			n.drv = 1'b0;
		end
		else if (stop_ev)
		begin
			n.st  = D_IDLE;
			n.drv = 1'b0;
		end
		else if (scl_rise && r.st != D_IDLE && r.st != D_IGNORE)
		begin
			// Sample on the rising edge, the start of the stable high
			if (r.cnt < 4'h8)
			begin
				n.sh  = {r.sh[6:0], f_sda};
				n.cnt = r.cnt + 4'h1;
			end
			else
			begin
				n.cnt = 4'h9;
				if (r.st == D_RDATA && f_sda)
					n.st = D_IGNORE;
			end
		end
		else if (scl_fall && r.st != D_IDLE && r.st != D_IGNORE)
		begin
			// Drive changes only after SCL has fallen
			if (r.cnt == 4'h8)
			begin
				case (r.st)
					D_ADDR:
					begin
						if (r.sh[7:1] == own_addr)
						begin
							n.drv = 1'b1;
							if (r.sh[0])
							begin
								n.st     = D_RDATA;
								n.tx     = applied(r, r.ch);
								n.rd_idx = 1'b0;
							end
							else
								n.st = D_INSTR;
						end
						else
							n.st = D_IGNORE;
					end
					D_INSTR:
					begin
						n.drv = 1'b1;
						n.st  = D_WDATA;
						n.ch  = r.sh[`OTPW_CHANNEL_SELECT_BIT];
						n.shut = r.sh[`OTPW_WIPER_TO_B_SHUTDOWN_BIT];
						// Snapshot before override so turning it off restores
						if (r.sh[`OTPW_FUSE_OVERRIDE_BIT] && !r.ovr)
							n.ovw = r.wip;
						n.ovr = r.sh[`OTPW_FUSE_OVERRIDE_BIT];
						// Low three bits never read; only a ready part burns
						if (r.sh[`OTPW_FUSE_PROGRAM_BIT] && r.stat == `OTPW_OTP_READY && !r.prog)
						begin
							n.prog  = 1'b1;
							n.pcnt  = 27'h0;
							n.fcode = r.wip;
						end
					end
					D_WDATA:
					begin
						n.drv = 1'b1;
						// Register updates even in shutdown
						if (r.ovr)
							n.ovw[r.ch] = r.sh;
						else if (r.stat != `OTPW_OTP_DONE)
							n.wip[r.ch] = r.sh;
					end
					D_RDATA:
					begin
						n.drv    = 1'b0;
						n.rd_idx = ~r.rd_idx;
						// Second byte carries status in its top pair
						if (r.rd_idx)
							n.tx = applied(r, r.ch);
						else
							n.tx = {r.stat, 6'h00};
					end
					default:
						n.drv = 1'b0;
				endcase
			end
			else if (r.cnt == 4'h9)
			begin
				n.cnt = 4'h0;
				n.drv = (r.st == D_RDATA) ? ~r.tx[7] : 1'b0;
			end
			else if (r.st == D_RDATA)
			begin
				n.drv = ~r.tx[6];
				n.tx  = {r.tx[6:0], 1'b0};
			end
		end
	end

	// Single state register
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			r        <= '0;
			r.st     <= D_IDLE;
			r.scl_d  <= 1'b1;
			r.sda_d  <= 1'b1;
			r.wip[0] <= `OTPW_MIDSCALE;
			r.wip[1] <= `OTPW_MIDSCALE;
		end
		else
			r <= n;
	end

	// Link pin, open drain
	assign LINK.dev_sda_out = 1'b0;
	assign LINK.dev_sda_oe  = r.drv;

	// Array and fuse outputs; wiper codes are a mux of registers
	assign SHUTDOWN_OUT        = r.shut;
	assign WIPER0_CODE_OUT     = applied(r, 1'b0);
	assign WIPER1_CODE_OUT     = applied(r, 1'b1);
	assign FUSE_PROG_OUT       = r.prog;
	assign FUSE_BURN_CODE0_OUT = r.fcode[0];
	assign FUSE_BURN_CODE1_OUT = r.fcode[1];
	assign OTP_STATUS_OUT      = r.stat;
endmodule

// file: src/otpw_controller.sv
// Controller end: register port in, two-wire master out
`include "otpw_map.svh"

module otpw_controller
	import otpw_pkg::*;
(
	// Clock and reset
	input  wire logic         CLK_IN,
	input  wire logic         RESET_N_IN,
	// Register port
	input  wire logic [7:0]   REG_ADDR_IN,
	input  wire logic [15:0]  REG_WDATA_IN,
	input  wire logic         REG_WR_IN,
	input  wire logic         REG_RD_IN,
	output logic      [15:0]  REG_RDATA_OUT,
	// Two-wire link
	otpw_link_if.host         LINK
);
	otpw_host_state_type r;
	otpw_host_state_type n;
	logic                f_sda;
	logic                tick;
	logic                tx_byte;
	logic [1:0]          last;

	// SDA comes back from the wire, so it is synchronised
	otpw_sync #(.W(1)) u_sync
	(
		.clk_in     (CLK_IN),
		.reset_n_in (RESET_N_IN),
		.pin_in     (LINK.sda),
		.level_out  (f_sda)
	);

	assign tick    = (r.qcnt == 8'(`OTPW_SCL_QUARTER_CYC - 1));
	assign tx_byte = ~r.rd | (r.bidx == 2'h0);
	assign last    = (r.rd | r.with_data) ? 2'h2 : 2'h1;

	// Next state: register port and bit sequencer
	always_comb
	begin
		n       = r;
		n.rdout = r.rdout;
		if (r.st != H_IDLE)
			n.qcnt = tick ? 8'h0 : r.qcnt + 8'h1;

		// Register reads answer one cycle later
		if (REG_RD_IN)
		begin
			case (REG_ADDR_IN)
				`OTPW_REG_INSTR:  n.rdout = {8'h00, r.instr};
				`OTPW_REG_WDATA:  n.rdout = {8'h00, r.wdata};
				`OTPW_REG_STATUS: n.rdout = {14'h0, r.nack, r.st != H_IDLE};
				`OTPW_REG_RDATA:  n.rdout = r.rdata;
				default:          n.rdout = 16'h0000;
			endcase
		end
		if (REG_WR_IN)
		begin
			case (REG_ADDR_IN)
				`OTPW_REG_INSTR: n.instr = REG_WDATA_IN[7:0] & 8'hef;
				`OTPW_REG_WDATA: n.wdata = REG_WDATA_IN[7:0];
				`OTPW_REG_CMD:
				begin
					// Ignored while a transfer runs
					if (r.st == H_IDLE)
					begin
						n.addr      = REG_WDATA_IN[6:0];
						n.rd        = REG_WDATA_IN[`OTPW_CMD_READ_BIT];
						n.with_data = REG_WDATA_IN[`OTPW_CMD_WITH_DATA_BIT];
						n.st        = H_START;
						n.q         = 2'h0;
						n.qcnt      = 8'h0;
						n.bidx      = 2'h0;
						n.bitn      = 4'h0;
						n.nack      = 1'b0;
						n.sh        = {REG_WDATA_IN[6:0], REG_WDATA_IN[`OTPW_CMD_READ_BIT]};
					end
				end
				default:
					n.nack = r.nack;
			endcase
		end

		// Quarter steps of SCL
		if (tick)
		begin
			n.q = r.q + 2'h1;
			case (r.st)
				H_START:
				begin
					if (r.q == 2'h0)
						n.sda_lo = 1'b1;
					else if (r.q == 2'h3)
					begin
						n.scl_lo = 1'b1;
						n.st     = H_BIT;
					end
				end
				H_BIT:
				begin
					if (r.q == 2'h0)
					begin
						// Data set only while SCL is low
						if (r.bitn < 4'h8)
							n.sda_lo = tx_byte & ~r.sh[7];
						else
							n.sda_lo = ~tx_byte & (r.bidx != last);
					end
					else if (r.q == 2'h1)
						n.scl_lo = 1'b0;
					else if (r.q == 2'h3)
					begin
						n.scl_lo = 1'b1;
						n.bitn   = r.bitn + 4'h1;
						if (r.bitn < 4'h8)
							n.sh = {r.sh[6:0], f_sda};
						else
						begin
							n.bitn = 4'h0;
							n.bidx = r.bidx + 2'h1;
							if (!tx_byte)
								n.rdata = (r.bidx == 2'h1) ? {r.rdata[15:8], r.sh}
									: {r.sh, r.rdata[7:0]};
							if ((tx_byte && f_sda) || r.bidx == last)
							begin
								n.nack = tx_byte & f_sda;
								n.st   = H_STOP;
							end
							else if (r.bidx == 2'h0)
								n.sh = r.rd ? 8'hff : r.instr;
							else
								n.sh = r.wdata;
						end
					end
				end
				H_STOP:
				begin
					if (r.q == 2'h0)
						n.sda_lo = 1'b1;
					else if (r.q == 2'h1)
						n.scl_lo = 1'b0;
					else if (r.q == 2'h3)
					begin
						n.sda_lo = 1'b0;
						n.st     = H_IDLE;
					end
				end
				default:
					n.st = H_IDLE;
			endcase
		end
	end

	// Single state register
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			r    <= '0;
			r.st <= H_IDLE;
		end
		else
			r <= n;
	end

	// Open-drain pins
	assign LINK.host_scl_out = 1'b0;
	assign LINK.host_scl_oe  = r.scl_lo;
	assign LINK.host_sda_out = 1'b0;
	assign LINK.host_sda_oe  = r.sda_lo;
	assign REG_RDATA_OUT     = r.rdout;
endmodule

// file: verification/otpw_link_chk.sv
// Concurrent checks on the two-wire link between controller and target
module otpw_link_chk
#(
	parameter logic [6:0] DEV_ADDR = 7'h00
)
(
	// Clock and reset
	input  wire logic CLK_IN,
	input  wire logic RESET_N_IN,
	// Controller drivers
	input  wire logic host_scl_out,
	input  wire logic host_scl_oe,
	input  wire logic host_sda_out,
	input  wire logic host_sda_oe,
	// Target drivers
	input  wire logic dev_sda_out,
	input  wire logic dev_sda_oe,
	// Resolved wires
	input  wire logic scl,
	input  wire logic sda
);
	logic       scl_d;
	logic       sda_d;
	logic [3:0] bitn;
	logic [2:0] byten;
	logic [7:0] sh;
	logic       hit;
	logic       rd;
	logic       rise;
	logic       start;
	logic       slot;

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RESET_N_IN);

	// Edges seen on the wires; slot marks the acknowledge clock
	assign rise  = scl & ~scl_d;
	assign start = scl & scl_d & sda_d & ~sda;
	assign slot  = rise & (bitn == 4'h8);

	// Bit and byte position since the last start, first byte captured
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			bitn  <= 4'h0;
			byten <= 3'h0;
			sh    <= 8'h00;
			hit   <= 1'b0;
			rd    <= 1'b0;
		end
		else
		begin
			scl_d <= scl;
			sda_d <= sda;
			if (start)
			begin
				bitn  <= 4'h0;
				byten <= 3'h0;
				hit   <= 1'b0;
			end
			else if (slot)
			begin
				bitn <= 4'h0;
				// Saturate so long frames never wrap back to the address byte
				if (byten != 3'h7)
					byten <= byten + 3'h1;
				if (byten == 3'h0)
				begin
					hit <= (sh[7:1] == DEV_ADDR);
					rd  <= sh[0];
				end
			end
			else if (rise)
			begin
				sh   <= {sh[6:0], sda};
				bitn <= bitn + 4'h1;
			end
		end
	end

	// Target keeps SDA pulled for 8 cycles from the rising edge of the ack clock
	sequence ack_held;
		dev_sda_oe[*8];
	endsequence

	// Controller lets SDA float high for the closing bit
	sequence host_let_go;
		!host_sda_oe && sda;
	endsequence

	dev_edge_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("target moved SDA while SCL high");
	dev_hold_high_a: assert property (rise |=> $stable(dev_sda_oe)[*8])
		else $error("target SDA not stable in SCL high");
	addr_ack_a: assert property (slot && byten == 3'h0 && sh[7:1] == DEV_ADDR |-> ack_held)
		else $error("own address not acknowledged");
	no_match_idle_a: assert property (slot && byten == 3'h0 && sh[7:1] != DEV_ADDR |-> !dev_sda_oe)
		else $error("foreign address acknowledged");
	write_ack_a: assert property (slot && hit && !rd && byten != 3'h0 |-> ack_held)
		else $error("written byte not acknowledged");
	read_drive_a: assert property (rise && !slot && hit && rd && byten == 3'h1 |-> !host_sda_oe)
		else $error("controller drives SDA in read data");
	read_release_a: assert property (slot && hit && rd && byten != 3'h0 |-> !dev_sda_oe)
		else $error("target holds SDA in read ack slot");
	read_nack_a: assert property (slot && hit && rd && byten == 3'h2 |-> host_let_go)
		else $error("read not closed by not-acknowledge");
	instr_bit4_a: assert property (rise && hit && !rd && byten == 3'h1 && bitn == 4'h3 |-> !sda)
		else $error("fourth instruction bit sent high");
	start_idle_a: assert property (start |-> !dev_sda_oe)
		else $error("target drives SDA at start");
endmodule

// file: verification/otpw_bench.sv
// Bench joining controller and wiper target through one link interface
`include "otpw_map.svh"

module otpw_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int          PROG_LEN = 20;
	localparam logic [6:0]  DEV_ADDR = {`OTPW_ADDR_UPPER, 2'h2};
	localparam logic [15:0] WR_DATA  = {8'h01, 1'b0, DEV_ADDR};
	localparam logic [15:0] WR_INSTR = {8'h00, 1'b0, DEV_ADDR};
	localparam logic [15:0] RD_CMD   = {8'h00, 1'b1, DEV_ADDR};

	logic        clk;
	logic        reset_n;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic [1:0]  fuse_status;
	logic [7:0]  fused0;
	logic [7:0]  fused1;
	logic        fuse_fail;
	logic        shutdown;
	logic        prog;
	logic [7:0]  w0;
	logic [7:0]  w1;
	logic [7:0]  burn0;
	logic [7:0]  burn1;
	logic [1:0]  otp_status;
	logic [15:0] rd_val;
	logic [15:0] prog_cnt;
	int          mismatches;
	int          tests_run;

	otpw_link_if i_otpw_link_if ();

	// Address pins pick low pair 10; burn result follows fuse_fail
	otpw_target #(.PROG_CYCLES(PROG_LEN), .USE_ADDR_PINS(1'b1)) i_otpw_target (
		.CLK_IN(clk), .RESET_N_IN(reset_n), .LINK(i_otpw_link_if),
		.ADDR_SELECT_PIN_LOW_IN(1'b0), .ADDR_SELECT_PIN_HIGH_IN(1'b1),
		.FUSE_STATUS_IN(fuse_status), .FUSED_CODE0_IN(fused0), .FUSED_CODE1_IN(fused1),
		.FUSE_FAIL_IN(fuse_fail), .SHUTDOWN_OUT(shutdown), .WIPER0_CODE_OUT(w0),
		.WIPER1_CODE_OUT(w1), .FUSE_PROG_OUT(prog), .FUSE_BURN_CODE0_OUT(burn0),
		.FUSE_BURN_CODE1_OUT(burn1), .OTP_STATUS_OUT(otp_status));

	otpw_controller i_otpw_controller (
		.CLK_IN(clk), .RESET_N_IN(reset_n), .REG_ADDR_IN(reg_addr),
		.REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
		.REG_RDATA_OUT(reg_rdata), .LINK(i_otpw_link_if));

	otpw_link_chk #(.DEV_ADDR(DEV_ADDR)) i_otpw_link_chk (
		.CLK_IN(clk), .RESET_N_IN(reset_n),
		.host_scl_out(i_otpw_link_if.host_scl_out), .host_scl_oe(i_otpw_link_if.host_scl_oe),
		.host_sda_out(i_otpw_link_if.host_sda_out), .host_sda_oe(i_otpw_link_if.host_sda_oe),
		.dev_sda_out(i_otpw_link_if.dev_sda_out), .dev_sda_oe(i_otpw_link_if.dev_sda_oe),
		.scl(i_otpw_link_if.scl), .sda(i_otpw_link_if.sda));

	// 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Length of each fuse burn pulse, cleared by every power cycle
	always @(posedge clk or negedge reset_n)
		if (!reset_n)
			prog_cnt <= 16'h0;
		else if (prog)
			prog_cnt <= prog_cnt + 16'h1;

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data appear in the cycle after the strobe and hold until the next read strobe
	task automatic reg_read(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask

	// One whole frame: load, start, poll busy under a bound
	task automatic transfer(input logic [15:0] cmd, input logic [7:0] instr, input logic [7:0] d);
		int n;
		reg_write(`OTPW_REG_INSTR, {8'h00, instr});
		reg_write(`OTPW_REG_WDATA, {8'h00, d});
		reg_write(`OTPW_REG_CMD, cmd);
		n = 0;
		rd_val = 16'h0001;
		while (rd_val[`OTPW_STAT_BUSY_BIT] !== 1'b0 && n < 4000)
		begin
			reg_read(`OTPW_REG_STATUS);
			n++;
		end
		check("frame finished", {15'h0, rd_val[`OTPW_STAT_BUSY_BIT]}, 16'h0);
	endtask

	// Power cycle with a given fuse array content
	task automatic power_up(input logic [1:0] fs, input logic [7:0] c0, input logic [7:0] c1);
		@(posedge clk);
		reset_n     <= 1'b0;
		fuse_status <= fs;
		fused0      <= c0;
		fused1      <= c1;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check("preset wiper 0", w0, (fs == `OTPW_OTP_DONE) ? c0 : `OTPW_MIDSCALE);
		check("preset wiper 1", w1, (fs == `OTPW_OTP_DONE) ? c1 : `OTPW_MIDSCALE);
		check("preset status", otp_status, fs);
	endtask

	task automatic test_preset();
		power_up(2'h0, 8'h11, 8'h22);
		reg_read(8'h20);
		check("unmapped read", rd_val, 16'h0000);
	endtask

	// Channel 2, shutdown, fourth and low bits set by the caller
	task automatic test_write_shutdown();
		transfer(WR_DATA, 8'hd7, 8'h3c);
		check("shutdown on", shutdown, 1'b1);
		check("wiper 1 loaded", w1, 8'h3c);
		check("wiper 0 untouched", w0, `OTPW_MIDSCALE);
	endtask

	// Instruction alone: channel 1, leave shutdown, burn fuses
	task automatic test_program();
		transfer(WR_INSTR, 8'h20, 8'h00);
		repeat (PROG_LEN + 8) @(posedge clk);
		#1;
		check("shutdown off", shutdown, 1'b0);
		check("wiper 1 kept", w1, 8'h3c);
		check("burn length", prog_cnt, 16'(PROG_LEN));
		check("burn code 0", burn0, `OTPW_MIDSCALE);
		check("burn code 1", burn1, 8'h3c);
		check("status burnt", otp_status, `OTPW_OTP_DONE);
	endtask

	task automatic test_read();
		transfer(RD_CMD, 8'h00, 8'h00);
		reg_read(`OTPW_REG_RDATA);
		check("read wiper", rd_val[7:0], `OTPW_MIDSCALE);
		check("read status", rd_val[15:14], `OTPW_OTP_DONE);
	endtask

	task automatic test_foreign_addr();
		transfer({8'h00, 1'b0, DEV_ADDR ^ 7'h01}, 8'h80, 8'h00);
		check("foreign nack", rd_val[`OTPW_STAT_NACK_BIT], 1'b1);
	endtask

	// Fused part: override, then plain write refused
	task automatic test_fused();
		power_up(2'h3, 8'h9a, 8'hc6);
		transfer(WR_DATA, 8'h88, 8'h22);
		check("override wiper", w1, 8'h22);
		transfer(WR_DATA, 8'h80, 8'h11);
		check("override dropped", w1, 8'hc6);
		power_up(2'h2, 8'h9a, 8'hc6);
	endtask

	// Ready part whose burn fails: status drops to failed
	task automatic test_fail();
		power_up(2'h0, 8'h55, 8'haa);
		@(posedge clk);
		fuse_fail <= 1'b1; // Never cleared: no second burn follows
		transfer(WR_INSTR, 8'h20, 8'h00);
		repeat (PROG_LEN + 8) @(posedge clk);
		#1;
		check("failed burn length", prog_cnt, 16'(PROG_LEN));
		check("status failed", otp_status, `OTPW_OTP_FAILED);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		reset_n     = 1'b0;
		reg_addr    = 8'h00;
		reg_wdata   = 16'h0000;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		fuse_status = 2'h0;
		fused0      = 8'h00;
		fused1      = 8'h00;
		fuse_fail   = 1'b0;
		mismatches  = 0;
		tests_run   = 0;
		test_preset();
		test_write_shutdown();
		test_program();
		test_read();
		test_foreign_addr();
		test_fused();
		test_fail();
		report_and_stop();
	end

	// Hang guard, well above seven frames of at most about 6000 cycles each
	initial
	begin
		repeat (60000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end
endmodule
